// *** core/pir_pkg.sv ***
// Package of constants and types for the priority interrupt resolver
// Function
// - Internal trap group, up to eight levels
// - External group, up to 24 levels
// - Unique priority number orders all levels
// - Any trap beats every external level
// - Lower level number wins within group
// - Divert flow to winning level's routine
// - Trap levels fixed to their sources
// - Trap logic present only when installed
// - Dedicated vectors: traps 060, externals 070
// - Traps always armed; externals need software
// - Disarmed triggers ignored; armed ones wait
// - Waiting becomes active at boundary, unheld
package pir_pkg;
	localparam int unsigned TRAP_LEVELS = 8;
	localparam int unsigned EXT_LEVELS  = 24;
	localparam int unsigned LINK_LINES  = 4;
	localparam int unsigned LINK_BASE   = 20;
	localparam int unsigned VEC_W       = 7;
	localparam logic [VEC_W-1:0] TRAP_VEC_BASE = 7'h30;
	localparam logic [VEC_W-1:0] EXT_VEC_BASE  = 7'h38;
	localparam int unsigned TRAP_PWR_DOWN  = 0;
	localparam int unsigned TRAP_PWR_UP    = 1;
	localparam int unsigned TRAP_RESTRICT  = 2;
	localparam int unsigned TRAP_INSTR     = 3;
	localparam int unsigned TRAP_STALL     = 4;
	localparam int unsigned TRAP_TIMER     = 5;
	localparam int unsigned TRAP_FPU       = 6;
	localparam logic [TRAP_LEVELS-1:0] TRAP_INSTALLED_DEF = 8'h7f;
	localparam logic [EXT_LEVELS-1:0]  EXT_RST = 24'h000000;
	typedef enum logic [2:0] {
		PIR_IDLE = 3'b001,
		PIR_TRAP = 3'b010,
		PIR_EXT  = 3'b100
	} pir_state_e;
endpackage : pir_pkg

// *** core/pir_enc_if.sv ***
// Interface carrying one priority encoder's request and result
`timescale 1ns/100ps
interface pir_enc_if #(parameter int unsigned N = 8, parameter int unsigned W = 3);
	logic [N-1:0] req;
	logic         hit;
	logic [W-1:0] idx;
	modport enc (input req, output hit, output idx);
	modport user (output req, input hit, input idx);
endinterface : pir_enc_if

// *** core/pir_prio_enc.sv ***
// Fixed priority encoder, lowest index wins
`timescale 1ns/100ps
module pir_prio_enc #(
	parameter int unsigned N = 8,
	parameter int unsigned W = 3
) (
	pir_enc_if.enc e
);
	// lowest index wins
	// Scan from the top so the lowest set bit is left last
	always_comb begin
		e.hit = 1'b0;
		e.idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (e.req[i]) begin
				e.hit = 1'b1;
				e.idx = W'(i);
			end
		end
	end
endmodule : pir_prio_enc

// *** core/pir_resolver.sv ***
// Priority interrupt resolver top: traps and external levels
`timescale 1ns/100ps
module pir_resolver
	import pir_pkg::*;
#(
	parameter logic [TRAP_LEVELS-1:0] TRAP_INSTALLED = TRAP_INSTALLED_DEF
) (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic [TRAP_LEVELS-1:0] trap_trig_i,
	input  wire logic [EXT_LEVELS-1:0]  ext_trig_i,
	input  wire logic [LINK_LINES-1:0]  link_trig_i,
	input  wire logic                   arm_wr_i,
	input  wire logic [EXT_LEVELS-1:0]  arm_i,
	input  wire logic [EXT_LEVELS-1:0]  enable_i,
	input  wire logic                   sw_trig_wr_i,
	input  wire logic [EXT_LEVELS-1:0]  sw_req_i,
	input  wire logic [EXT_LEVELS-1:0]  sw_act_i,
	input  wire logic                   hold_i,
	input  wire logic                   release_i,
	input  wire logic                   boundary_i,
	input  wire logic                   trap_done_i,
	input  wire logic                   ext_done_i,
	output logic                        divert_o,
	output logic [VEC_W-1:0]            vector_o,
	output logic                        in_trap_o,
	output logic [EXT_LEVELS-1:0]       arm_o,
	output logic [EXT_LEVELS-1:0]       enable_o,
	output logic [EXT_LEVELS-1:0]       wait_o,
	output logic [EXT_LEVELS-1:0]       active_o,
	output logic                        held_o
);
	// Registered state
	logic [TRAP_LEVELS-1:0] trap_s1_q, trap_s2_q, trap_prev_q, trap_pend_q;
	logic [EXT_LEVELS-1:0]  ext_s1_q, ext_s2_q, ext_prev_q;
	logic [EXT_LEVELS-1:0]  arm_q, en_q, wait_q, act_q;
	logic [LINK_LINES-1:0]  link_s1_q, link_s2_q;
	logic                   held_q, in_trap_q, divert_q;
	logic [VEC_W-1:0]       vec_q;
	pir_state_e             state_q, state_d;

	// Decode and selection nets
	logic [TRAP_LEVELS-1:0] trap_edge, trap_mask, trap_clr;
	logic [EXT_LEVELS-1:0]  ext_lvl, ext_edge, ext_new, on_line, higher_act;
	logic [EXT_LEVELS-1:0]  eligible, grant;
	logic [EXT_LEVELS-1:0]  act_set, act_clr, act_left;
	logic [VEC_W-1:0]       vec_d;
	logic                   take_trap, take_ext;

	pir_enc_if #(.N(TRAP_LEVELS), .W(3)) trap_if ();
	pir_enc_if #(.N(EXT_LEVELS),  .W(5)) ext_if ();

	// Two-stage synchronisers; triggers arrive from other clock domains
	// Only the second stage of each pair is read by the logic
	always_ff @(posedge clk_i) begin
		trap_s1_q <= trap_trig_i;
		trap_s2_q <= trap_s1_q;
		ext_s1_q  <= ext_trig_i;
		ext_s2_q  <= ext_s1_q;
		link_s1_q <= link_trig_i;
		link_s2_q <= link_s1_q;
	end

	assign trap_mask = TRAP_INSTALLED;
	assign trap_edge = trap_s2_q & ~trap_prev_q & trap_mask;

	generate
		for (genvar g = 0; g < EXT_LEVELS; g++) begin : g_lvl
			if (g >= LINK_BASE && g < LINK_BASE + LINK_LINES) begin : g_lk
				assign ext_lvl[g] = ext_s2_q[g] | link_s2_q[g - LINK_BASE];
			end else begin : g_pl
				assign ext_lvl[g] = ext_s2_q[g];
			end
			// Levels above this one that are active and on line
			if (g == 0) begin : g_h0
				assign higher_act[g] = 1'b0;
			end else begin : g_hn
				assign higher_act[g] = |(on_line[g-1:0]);
			end
		end
	endgenerate

	// A level held high asks once; only its rising edge counts
	assign ext_edge = ext_lvl & ~ext_prev_q;
	assign ext_new  = (ext_edge | (sw_trig_wr_i ? sw_req_i : EXT_RST)) & arm_q;
	// An inhibited active level is permissive and lets lower levels in
	assign on_line  = act_q & en_q;
	assign eligible = wait_q & arm_q & en_q & ~higher_act & ~on_line;

	// Encoders see only what may be taken now
	assign trap_if.req = trap_pend_q;
	assign ext_if.req  = eligible;
	pir_prio_enc #(.N(TRAP_LEVELS), .W(3)) u_trap_enc (.e(trap_if));
	pir_prio_enc #(.N(EXT_LEVELS),  .W(5)) u_ext_enc  (.e(ext_if));

	assign take_trap = boundary_i & trap_if.hit & ~in_trap_q;
	assign take_ext  = boundary_i & ~take_trap & ~in_trap_q & ext_if.hit
	                 & ~held_q;
	assign grant = take_ext ? (EXT_LEVELS'(1) << ext_if.idx) : EXT_RST;

	// Trap level taken now leaves the pending set
	assign trap_clr = take_trap ? (8'h01 << trap_if.idx) : 8'h00;

	// Software may mark levels active directly, next to the grant
	assign act_set = grant | (sw_trig_wr_i ? sw_act_i : EXT_RST);
	// A finished routine retires the most urgent on-line active level.
	// Keyed to no trap running rather than to the ext state, so that a
	// routine which a trap preempted can still retire after the trap.
	assign act_clr = (ext_done_i && state_q != PIR_TRAP)
	               ? (on_line & ~higher_act)
	               : EXT_RST;
	assign act_left = act_q & ~act_clr;

	// Vector of the level taken; unchanged when nothing is taken
	assign vec_d = take_trap ? (TRAP_VEC_BASE + VEC_W'(trap_if.idx))
	             : take_ext  ? (EXT_VEC_BASE + VEC_W'(ext_if.idx))
	             : vec_q;

	// Service state: a trap routine runs to completion before anything else
	// An ext routine may be preempted by a trap, never the reverse
	always_comb begin
		state_d = state_q;
		case (state_q)
			PIR_IDLE: begin
				if (take_trap) state_d = PIR_TRAP;
				else if (take_ext) state_d = PIR_EXT;
			end
			PIR_TRAP: begin
				if (trap_done_i) state_d = PIR_IDLE;
			end
			PIR_EXT: begin
				if (take_trap) state_d = PIR_TRAP;
				else if (ext_done_i && !(|act_left)) state_d = PIR_IDLE;
			end
			default: state_d = PIR_IDLE;
		endcase
	end

	// Trap pending latch; a new edge wins over the clear of its level
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			trap_prev_q <= '0;
			trap_pend_q <= '0;
		end else begin
			trap_prev_q <= trap_s2_q;
			trap_pend_q <= (trap_pend_q & ~trap_clr) | trap_edge;
		end
	end

	// Arm and enable registers, loaded whole by software
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			arm_q <= EXT_RST;
			en_q  <= EXT_RST;
		end else if (arm_wr_i) begin
			arm_q <= arm_i;
			en_q  <= enable_i;
		end
	end

	// Waiting and active; new triggers win over the grant clearing wait
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ext_prev_q <= EXT_RST;
			wait_q     <= EXT_RST;
			act_q      <= EXT_RST;
		end else begin
			ext_prev_q <= ext_lvl;
			wait_q     <= (wait_q & ~grant) | ext_new;
			act_q      <= (act_q | act_set) & ~act_clr;
		end
	end

	// Hold flag: set wins if hold and release come together
	always_ff @(posedge clk_i) begin
		if (!resetn_i) held_q <= 1'b0;
		else if (hold_i) held_q <= 1'b1;
		else if (release_i) held_q <= 1'b0;
	end

	// Service state and trap flag move together
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_q   <= PIR_IDLE;
			in_trap_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			in_trap_q <= (state_d == PIR_TRAP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			divert_q <= 1'b0;
			vec_q    <= '0;
		end else begin
			divert_q <= take_trap | take_ext;
			vec_q    <= vec_d;
		end
	end

	// Outputs straight from their flops
	assign divert_o  = divert_q;
	assign vector_o  = vec_q;
	assign in_trap_o = in_trap_q;
	assign arm_o     = arm_q;
	assign enable_o  = en_q;
	assign wait_o    = wait_q;
	assign active_o  = act_q;
	assign held_o    = held_q;
endmodule : pir_resolver

// *** verification/pir_trig_src.sv ***
// Trigger sources: devices, CPU functions and companion link
`timescale 1ns/100ps
module pir_trig_src
	import pir_pkg::*;
(
	input  wire logic              clk_i,
	output logic [TRAP_LEVELS-1:0] trap_trig_o,
	output logic [EXT_LEVELS-1:0]  ext_trig_o,
	output logic [LINK_LINES-1:0]  link_trig_o
);
	initial begin
		trap_trig_o = '0;
		ext_trig_o = '0;
		link_trig_o = '0;
	end
	// Held five cycles so the two-stage sync cannot miss it
	// link lines driven
	task automatic fire(input int k, input int n);
		@(posedge clk_i);
		#1;
		if (k == 0) trap_trig_o[n] = 1'b1;
		else if (k == 1) ext_trig_o[n] = 1'b1;
		else link_trig_o[n] = 1'b1;
		repeat (5) @(posedge clk_i);
		#1;
		trap_trig_o = '0;
		ext_trig_o = '0;
		link_trig_o = '0;
	endtask : fire
endmodule : pir_trig_src

// *** verification/pir_resolver_monitor.sv ***
// Port checker for the resolver
`timescale 1ns/100ps
module pir_resolver_monitor
	import pir_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  resetn_i,
	input wire logic                  boundary_i,
	input wire logic                  divert_o,
	input wire logic [VEC_W-1:0]      vector_o,
	input wire logic                  in_trap_o,
	input wire logic [EXT_LEVELS-1:0] arm_o,
	input wire logic [EXT_LEVELS-1:0] enable_o,
	input wire logic [EXT_LEVELS-1:0] wait_o,
	input wire logic [EXT_LEVELS-1:0] active_o,
	input wire logic                  held_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Ext grant decode and mask of the levels above it
	wire logic [VEC_W-1:0] ix = vector_o - EXT_VEC_BASE;
	wire logic [EXT_LEVELS-1:0] up = (24'h1 << ix) - 24'h1;
	wire logic ed = divert_o && !in_trap_o;
	chk_grant_cause: assert property (divert_o |-> $past(boundary_i))
		else $error("divert without boundary");
	chk_trap_no_nest: assert property (divert_o |-> !$past(in_trap_o))
		else $error("grant during trap");
	chk_trap_vector: assert property ($rose(in_trap_o) |->
		divert_o && vector_o[6:3] == 4'h6) else $error("bad trap vector");
	chk_ext_range: assert property (ed |->
		vector_o >= EXT_VEC_BASE && vector_o <= 7'h4f) else $error("bad vector");
	chk_ext_active: assert property (ed |-> active_o[ix])
		else $error("granted level not active");
	chk_hold_blocks: assert property (ed |-> !$past(held_o))
		else $error("ext grant while held");
	chk_prio_order: assert property (ed |-> ($past(wait_o) &
		$past(arm_o) & $past(enable_o) & up) == '0) else $error("lower won");
	chk_disarm_drop: assert property ((wait_o & ~$past(wait_o) &
		~arm_o & ~$past(arm_o)) == '0) else $error("disarmed level waits");
	cover property (ed);
	cover property ($rose(in_trap_o));
	cover property (held_o && boundary_i);
endmodule : pir_resolver_monitor
bind pir_resolver pir_resolver_monitor u_mon (.clk_i(clk_i),
	.resetn_i(resetn_i), .boundary_i(boundary_i), .divert_o(divert_o),
	.vector_o(vector_o), .in_trap_o(in_trap_o), .arm_o(arm_o),
	.enable_o(enable_o), .wait_o(wait_o), .active_o(active_o),
	.held_o(held_o));

// *** verification/tb_priority_interrupt_resolver.sv ***
// Self-checking bench for the priority interrupt resolver
`timescale 1ns/100ps
module tb_priority_interrupt_resolver
	import pir_pkg::*;
;
	logic clk_i, resetn_i, arm_wr_i, hold_i, release_i, boundary_i;
	logic trap_done_i, ext_done_i, divert_o, in_trap_o, held_o, sw_trig_wr_i;
	logic [TRAP_LEVELS-1:0] trap_trig_i;
	logic [EXT_LEVELS-1:0] ext_trig_i, arm_i, enable_i, arm_o, enable_o;
	logic [EXT_LEVELS-1:0] wait_o, active_o, sw_req_i, sw_act_i;
	logic [LINK_LINES-1:0] link_trig_i;
	logic [VEC_W-1:0] vector_o;
	int n_fail, num_checks;
	pir_trig_src src (.clk_i(clk_i), .trap_trig_o(trap_trig_i),
		.ext_trig_o(ext_trig_i), .link_trig_o(link_trig_i));
	pir_resolver uut (.clk_i(clk_i), .resetn_i(resetn_i),
		.trap_trig_i(trap_trig_i), .ext_trig_i(ext_trig_i),
		.link_trig_i(link_trig_i), .arm_wr_i(arm_wr_i), .arm_i(arm_i),
		.enable_i(enable_i), .sw_trig_wr_i(sw_trig_wr_i),
		.sw_req_i(sw_req_i), .sw_act_i(sw_act_i), .hold_i(hold_i),
		.release_i(release_i),
		.boundary_i(boundary_i), .trap_done_i(trap_done_i),
		.ext_done_i(ext_done_i), .divert_o(divert_o), .vector_o(vector_o),
		.in_trap_o(in_trap_o), .arm_o(arm_o), .enable_o(enable_o),
		.wait_o(wait_o), .active_o(active_o), .held_o(held_o));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// One-cycle strobe; divert shows right after it
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge clk_i);
		#1 s = 1'b0;
	endtask : pulse
	task automatic setae(input logic [23:0] a, input logic [23:0] e);
		arm_i = a;
		enable_i = e;
		pulse(arm_wr_i);
	endtask : setae
	task automatic t_order();
		setae('1, '1);
		src.fire(1, 9);
		src.fire(1, 5);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + 5);
		chk(active_o[5], 1);
		pulse(ext_done_i);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + 9);
		pulse(ext_done_i);
	endtask : t_order
	task automatic t_trap();
		src.fire(1, 3);
		src.fire(0, TRAP_STALL);
		pulse(boundary_i);
		chk(vector_o, TRAP_VEC_BASE + TRAP_STALL);
		chk(in_trap_o, 1);
		pulse(trap_done_i);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + 3);
		pulse(ext_done_i);
	endtask : t_trap
	task automatic t_arm();
		setae('0, '1);
		src.fire(1, 2);
		chk(wait_o, 0);
		setae('1, '0);
		chk(arm_o, 24'hffffff);
		chk(enable_o, 0);
		src.fire(1, 7);
		pulse(boundary_i);
		chk({wait_o[7], divert_o}, 2'b10);
		setae('1, '1);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + 7);
		pulse(ext_done_i);
	endtask : t_arm
	task automatic t_hold();
		pulse(hold_i);
		chk(held_o, 1);
		src.fire(1, 0);
		pulse(boundary_i);
		chk(divert_o, 0);
		pulse(release_i);
		chk(held_o, 0);
		pulse(boundary_i);
		chk({divert_o, vector_o}, {1'b1, EXT_VEC_BASE});
		pulse(ext_done_i);
	endtask : t_hold
	task automatic t_link();
		src.fire(2, 1);
		chk(wait_o[LINK_BASE+1], 1);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + LINK_BASE + 1);
		pulse(ext_done_i);
		src.fire(0, 7);
		pulse(boundary_i);
		chk(divert_o, 0);
	endtask : t_link
	// Software request and active load, higher-level block, trap preempt
	task automatic t_soft();
		setae(24'hfffffb, '1);
		sw_req_i = 24'h000044;
		sw_act_i = 24'h000010;
		pulse(sw_trig_wr_i);
		chk(wait_o, 24'h000040);
		chk(active_o, 24'h000010);
		pulse(boundary_i);
		chk(divert_o, 0);
		src.fire(0, TRAP_TIMER);
		pulse(boundary_i);
		chk(vector_o, TRAP_VEC_BASE + TRAP_TIMER);
		pulse(trap_done_i);
		pulse(ext_done_i);
		chk(active_o, 0);
		pulse(boundary_i);
		chk(vector_o, EXT_VEC_BASE + 6);
		pulse(ext_done_i);
	endtask : t_soft
	// Reset in mid-run drops arming and hold
	task automatic t_reset();
		setae('1, '1);
		pulse(hold_i);
		resetn_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		chk(arm_o, 0);
		chk(enable_o, 0);
		chk(held_o, 0);
		src.fire(1, 4);
		pulse(boundary_i);
		chk(divert_o, 0);
	endtask : t_reset
	task automatic end_sim();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Hang guard, far beyond the roughly 110 cycles used
	initial begin
		#20000;
		n_fail++;
		end_sim();
	end
	initial begin
		{resetn_i, arm_wr_i, hold_i, release_i, boundary_i} = '0;
		{trap_done_i, ext_done_i, arm_i, enable_i} = '0;
		{sw_trig_wr_i, sw_req_i, sw_act_i} = '0;
		repeat (6) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		t_order();
		t_trap();
		t_arm();
		t_hold();
		t_link();
		t_soft();
		t_reset();
		end_sim();
	end
endmodule : tb_priority_interrupt_resolver
